// ==== core/umpf_top.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - With filtering on, frames without address indication never reach the buffer.
// - With five to eight data bits, the first stop bit gives frame type.
// - With nine data bits, the received ninth bit gives frame type.
// - Frame-type bit one means address frame; zero means data frame.
// - Transmitter behaviour does not depend on the filter enable.
// - Accepted address frame sets receive-complete just like normal reception.
// - After enable clears, all frames are accepted; else wait for address frame.
// - Filter enable shares the register word with transmit-complete flag.
// - Sixteen samples per bit normally, eight in double speed.
// - First voting sample is 8 normally, 4 in double speed.
// - Middle voting sample is 9 normally, 5 in double speed.
// - Character plus parity length runs from five to ten bits.
// - Each bit is the majority of three centre samples.
module umpf_top
  import umpf_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial line and transmitter status
  input  wire logic        rxd,
  input  wire logic        tx_done,
  // Interrupt
  output logic             irq
);
  // Control and status state
  logic              multiproc_filter_bit_r;
  logic              double_speed_select_r;
  logic              tx_complete_flag_r;
  logic              rx_complete_flag_r;
  logic              frame_err_r;
  logic              overrun_r;
  logic              rx_enable_r;
  logic [2:0]        char_size_select_r;
  logic              parity_en_r;
  logic [11:0]       baud_div_r;
  logic [8:0]        serial_data_reg_r;
  logic [IRQ_W-1:0]  irq_stat_r;
  logic [IRQ_W-1:0]  irq_mask_r;
  logic [IRQ_W-1:0]  irq_set;
  logic [IRQ_W-1:0]  irq_clr;

  // Bus handshake state
  logic              aw_have_r;
  logic              w_have_r;
  logic [7:0]        aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              wr_go;
  logic              rd_go;
  logic [31:0]       wmask;

  // Receiver interface
  logic              sample_en;
  logic              rx_done;
  logic [9:0]        rx_bits;
  logic              rx_stop;
  logic [3:0]        data_bits;
  logic [3:0]        frame_bits;
  logic              ninth_mode;
  logic              frame_type;
  logic              accept;
  logic              drop;
  logic              data_read;

  // Register hit test, shared by read and write paths
  function automatic logic reg_hit(input logic [7:0] a);
    reg_hit = (a == OFF_CTRL_A) || (a == OFF_CTRL_B) || (a == OFF_DATA) ||
              (a == OFF_BAUD) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
  endfunction

  // Data bit count from the size field; codes above four saturate at nine
  function automatic logic [3:0] csz_bits(input logic [2:0] sel);
    csz_bits = (sel >= CSZ_NINE) ? NINE_BITS : MIN_BITS + {1'b0, sel};
  endfunction

  // Sample rate divider and receiver core
  umpf_baud u_baud (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .divisor   (baud_div_r),
    .sample_en (sample_en)
  );

  umpf_rx u_rx (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .enable       (rx_enable_r),
    .sample_en    (sample_en),
    .double_speed (double_speed_select_r),
    .frame_bits   (frame_bits),
    .rxd          (rxd),
    .done         (rx_done),
    .bits         (rx_bits),
    .stop_bit     (rx_stop)
  );

  // Frame length is data bits plus an optional parity bit
  assign data_bits  = csz_bits(char_size_select_r);
  assign frame_bits = data_bits + {3'h0, parity_en_r};
  assign ninth_mode = (data_bits == NINE_BITS);

  // Frame type: ninth bit in nine-bit mode, else first stop bit
  assign frame_type = ninth_mode ? rx_bits[NINTH_POS] : rx_stop;
  // A one marks an address frame, a zero a data frame
  assign accept = rx_done && (frame_type || !multiproc_filter_bit_r);
  assign drop   = rx_done && !frame_type && multiproc_filter_bit_r;

  // Bus strobes
  assign wr_go     = aw_have_r && w_have_r && !s_axi_bvalid;
  assign rd_go     = s_axi_arvalid && s_axi_arready;
  assign data_read = rd_go && (s_axi_araddr == OFF_DATA);
  assign wmask     = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                      {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  // Write address and data are caught separately, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r     <= 1'b0;
      w_have_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= ZERO32;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
      // Ready only while the holding slot is free
      // Kept low while an answer waits, so no new write slips in under it
      s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready) &&
                       !(s_axi_bvalid && !s_axi_bready);
      s_axi_wready  <= !w_have_r && !(s_axi_wvalid && s_axi_wready) &&
                       !(s_axi_bvalid && !s_axi_bready);
    end
  end

  // Write response; unmapped addresses answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= reg_hit(aw_addr_r) ? RESP_OK : RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel: one read in flight, answered one cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= ZERO32;
      s_axi_rresp   <= RESP_OK;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= reg_hit(s_axi_araddr) ? RESP_OK : RESP_ERR;
      s_axi_rdata   <= ZERO32;
      case (s_axi_araddr)
        OFF_CTRL_A: begin
          s_axi_rdata[B_FILTER] <= multiproc_filter_bit_r;
          s_axi_rdata[B_DSPEED] <= double_speed_select_r;
          s_axi_rdata[B_OVRUN]  <= overrun_r;
          s_axi_rdata[B_FRMERR] <= frame_err_r;
          s_axi_rdata[B_TXC]    <= tx_complete_flag_r;
          s_axi_rdata[B_RXC]    <= rx_complete_flag_r;
        end
        OFF_CTRL_B: begin
          s_axi_rdata[B_RXEN]             <= rx_enable_r;
          s_axi_rdata[B_CSZ_LO+:3]        <= char_size_select_r;
          s_axi_rdata[B_PAREN]            <= parity_en_r;
        end
        OFF_DATA:     s_axi_rdata[8:0]       <= serial_data_reg_r;
        OFF_BAUD:     s_axi_rdata[11:0]      <= baud_div_r;
        OFF_IRQ_STAT: s_axi_rdata[IRQ_W-1:0] <= irq_stat_r;
        OFF_IRQ_MASK: s_axi_rdata[IRQ_W-1:0] <= irq_mask_r;
        default:      s_axi_rdata            <= ZERO32;
      endcase
    end else begin
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      s_axi_arready <= !s_axi_rvalid || s_axi_rready;
    end
  end

  // Plain configuration registers, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      multiproc_filter_bit_r <= 1'b0;
      double_speed_select_r  <= 1'b0;
      rx_enable_r            <= 1'b0;
      char_size_select_r     <= 3'h0;
      parity_en_r            <= 1'b0;
      baud_div_r             <= BAUD_RST;
      irq_mask_r             <= '0;
    end else if (wr_go && w_strb_r[0]) begin
      case (aw_addr_r)
        OFF_CTRL_A: begin
          // Whole-word write: a set-bit or clear-bit style read-modify-write
          // would write back a one to the completion flag and clear it
          multiproc_filter_bit_r <= w_data_r[B_FILTER];
          double_speed_select_r  <= w_data_r[B_DSPEED];
        end
        OFF_CTRL_B: begin
          rx_enable_r        <= w_data_r[B_RXEN];
          char_size_select_r <= w_data_r[B_CSZ_LO+:3];
          parity_en_r        <= w_data_r[B_PAREN];
        end
        OFF_BAUD: baud_div_r <= (w_data_r[11:0] & wmask[11:0]) | (baud_div_r & ~wmask[11:0]);
        OFF_IRQ_MASK: irq_mask_r <= w_data_r[IRQ_W-1:0];
        default: ;
      endcase
    end else if (wr_go && w_strb_r[1] && aw_addr_r == OFF_BAUD) begin
      baud_div_r[11:8] <= w_data_r[11:8];
    end
  end

  // Transmit-complete: set by the transmitter whatever the filter says,
  // cleared by writing one; a set in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_complete_flag_r <= 1'b0;
    end else if (tx_done) begin
      tx_complete_flag_r <= 1'b1;
    end else if (wr_go && w_strb_r[0] && aw_addr_r == OFF_CTRL_A && w_data_r[B_TXC]) begin
      tx_complete_flag_r <= 1'b0;
    end
  end

  // Receive buffer; a dropped frame leaves data and flags alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_complete_flag_r <= 1'b0;
      serial_data_reg_r  <= 9'h000;
      frame_err_r        <= 1'b0;
      overrun_r          <= 1'b0;
    end else if (!rx_enable_r) begin
      rx_complete_flag_r <= 1'b0; // Disabling flushes the buffer
    end else if (accept && (!rx_complete_flag_r || data_read)) begin
      // Accepted frame, address or not, completes as a normal reception
      rx_complete_flag_r <= 1'b1;
      serial_data_reg_r  <= ninth_mode ? rx_bits[8:0] : {1'b0, rx_bits[7:0]};
      frame_err_r        <= !rx_stop;
      overrun_r          <= 1'b0;
    end else if (accept) begin
      overrun_r <= 1'b1; // Buffer still full: frame lost, old data kept
    end else if (data_read) begin
      rx_complete_flag_r <= 1'b0;
    end
  end

  // Interrupt events; set has priority over the write-one clear
  assign irq_set = {tx_done, drop, accept && frame_type, accept};
  assign irq_clr = (wr_go && w_strb_r[0] && aw_addr_r == OFF_IRQ_STAT) ?
                   w_data_r[IRQ_W-1:0] : '0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      irq        <= |(irq_stat_r & irq_mask_r);
    end
  end
endmodule

// ==== core/umpf_pkg.sv ====
package umpf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_A   = 8'h00;
  localparam logic [7:0] OFF_CTRL_B   = 8'h04;
  localparam logic [7:0] OFF_DATA     = 8'h08;
  localparam logic [7:0] OFF_BAUD     = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  // Bits of serial_ctrl_status_a
  localparam int B_FILTER = 0;
  localparam int B_DSPEED = 1;
  localparam int B_OVRUN  = 3;
  localparam int B_FRMERR = 4;
  localparam int B_TXC    = 6;
  localparam int B_RXC    = 7;
  // Fields of control b
  localparam int B_RXEN   = 0;
  localparam int B_CSZ_LO = 1;
  localparam int B_PAREN  = 4;
  // Interrupt event bits
  localparam int I_RXC    = 0;
  localparam int I_ADDR   = 1;
  localparam int I_DROP   = 2;
  localparam int I_TXC    = 3;
  localparam int IRQ_W    = 4;
  // Frame format
  localparam logic [3:0] MIN_BITS   = 4'h5;
  localparam logic [3:0] NINE_BITS  = 4'h9;
  localparam logic [2:0] CSZ_NINE   = 3'h4;
  localparam int         NINTH_POS  = 8;
  // Oversampling: samples per bit and first voting sample
  localparam logic [4:0] S_NORM  = 5'h10;
  localparam logic [4:0] S_DBL   = 5'h08;
  localparam logic [4:0] SF_NORM = 5'h08;
  localparam logic [4:0] SF_DBL  = 5'h04;
  // Reset values
  localparam logic [11:0] BAUD_RST = 12'h000;
  localparam logic [31:0] ZERO32   = 32'h0000_0000;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  // Receiver states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_BITS  = 2'b10,
    ST_STOP  = 2'b11
  } umpf_rx_state_t;
endpackage

// ==== core/umpf_baud.sv ====
`timescale 1ns/1ps
module umpf_baud
  import umpf_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Divisor
  input  wire logic [11:0] divisor,
  // Sample enable
  output logic             sample_en
);
  logic [11:0] cnt_r;

  // One tick every divisor+1 clocks; same rate in both speed modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r     <= BAUD_RST;
      sample_en <= 1'b0;
    end else if (cnt_r >= divisor) begin
      cnt_r     <= BAUD_RST;
      sample_en <= 1'b1;
    end else begin
      cnt_r     <= cnt_r + 12'h001;
      sample_en <= 1'b0;
    end
  end
endmodule

// ==== core/umpf_rx.sv ====
`timescale 1ns/1ps
module umpf_rx
  import umpf_pkg::*;
(
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       enable,
  input  wire logic       sample_en,
  input  wire logic       double_speed,
  input  wire logic [3:0] frame_bits,
  // Serial pin
  input  wire logic       rxd,
  // Received frame
  output logic            done,
  output logic [9:0]      bits,
  output logic            stop_bit
);
  umpf_rx_state_t state_r;
  logic [1:0] sync_r;
  logic [4:0] cnt_r;
  logic [4:0] nc;
  logic [4:0] spb;
  logic [4:0] sf;
  logic [3:0] bitn_r;
  logic       s0_r;
  logic       s1_r;
  logic       vote;

  function automatic logic maj(input logic a, input logic b, input logic c);
    maj = (a & b) | (a & c) | (b & c);
  endfunction

  // Two flops before the pin is looked at
  always_ff @(posedge aclk) begin
    if (!aresetn) sync_r <= 2'b11;
    else          sync_r <= {sync_r[0], rxd};
  end

  // Samples per bit and voting window by speed mode
  assign spb  = double_speed ? S_DBL : S_NORM;
  assign sf   = double_speed ? SF_DBL : SF_NORM;
  assign nc   = (cnt_r == spb) ? 5'h01 : cnt_r + 5'h01;
  assign vote = maj(s0_r, s1_r, sync_r[1]);

  // Sample numbering starts at 1 on the first low sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 5'h01;
      bitn_r   <= 4'h0;
      s0_r     <= 1'b1;
      s1_r     <= 1'b1;
      done     <= 1'b0;
      bits     <= 10'h000;
      stop_bit <= 1'b1;
    end else begin
      done <= 1'b0;
      if (!enable) begin
        state_r <= ST_IDLE;
      end else if (sample_en) begin
        if (state_r == ST_IDLE) begin
          if (!sync_r[1]) begin
            state_r <= ST_START;
            cnt_r   <= 5'h01;
          end
        end else begin
          cnt_r <= nc;
          if (nc == sf) s0_r <= sync_r[1];
          if (nc == sf + 5'h01) s1_r <= sync_r[1];
          if (nc == sf + 5'h02) begin
            case (state_r)
              ST_START: begin
                state_r <= vote ? ST_IDLE : ST_BITS; // Spike rejected
                bitn_r  <= 4'h0;
                bits    <= 10'h000; // Short frames must not show older high bits
              end
              ST_BITS: begin
                bits[bitn_r] <= vote;
                bitn_r       <= bitn_r + 4'h1;
                if (bitn_r == frame_bits - 4'h1) state_r <= ST_STOP;
              end
              ST_STOP: begin
                // Only the first stop bit is used; next start may follow at once
                stop_bit <= vote;
                done     <= 1'b1;
                state_r  <= ST_IDLE;
              end
              default: state_r <= ST_IDLE;
            endcase
          end
        end
      end
    end
  end
endmodule

// ==== tb/umpf_checker.sv ====
`timescale 1ns/1ps
module umpf_checker
  import umpf_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Transmitter status and interrupt
  input wire logic        tx_done,
  input wire logic        irq
);
  logic             wr_hs;
  logic [IRQ_W-1:0] mask_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Both write channels taken at one edge
  assign wr_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;

  // Mask mirror; the pin can only be judged against what software enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= '0;
    end else if (wr_hs && s_axi_awaddr == OFF_IRQ_MASK) begin
      mask_r <= s_axi_wdata[IRQ_W-1:0];
    end
  end

  // Bus answers: write two edges, read one edge on; one beat, no overlap
  wr_resp_a: assert property (wr_hs |-> ##2 s_axi_bvalid)
    else $error("write answer not two cycles after request");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  b_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after request");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  r_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");

  // Transmit completion reaches the pin two edges later, filter or not
  tx_irq_a: assert property (tx_done && mask_r[I_TXC] |-> ##2 irq)
    else $error("transmit completion missed the interrupt");
  irq_mask_a: assert property (mask_r == '0 |=> !irq)
    else $error("interrupt with every source masked");

  cover property (tx_done && mask_r[I_TXC]);
  cover property ($rose(irq));
  cover property (wr_hs && s_axi_awaddr == OFF_IRQ_MASK);
endmodule

// ==== tb/umpf_line_master.sv ====
`timescale 1ns/1ps
module umpf_line_master
  import umpf_pkg::*;
(
  // Clock
  input  wire logic aclk,
  // Shared serial line, idle high
  output logic      rxd
);
  // Line idles high before the first frame
  initial rxd = 1'b1;

  // Hold one level for a number of clocks, changing just after an edge
  task automatic drive(input logic v, input int clks);
    @(posedge aclk);
    rxd <= v;
    repeat (clks - 1) @(posedge aclk);
  endtask

  // Start, n bits LSB first, frame-type stop (always high in nine-bit frames), spare stop
  task automatic send(input logic [9:0] b, input int n, input logic ad,
                      input logic nine, input int per);
    logic [9:0] f;
    f = b;
    if (nine) f[NINTH_POS] = ad;
    drive(1'b0, per);
    for (int i = 0; i < n; i++) drive(f[i], per);
    drive(nine | ad, per);
    drive(1'b1, per);
  endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import umpf_pkg::*;
;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, rxd, tx_done, irq;
  int          err_count;
  int          cmp_count;

  // Block under test; every register is one full word
  umpf_top u_umpf_top (
    .aclk(aclk), .aresetn(aresetn), .rxd(rxd), .tx_done(tx_done), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );

  // Far-side sender on the serial line
  umpf_line_master u_line (.aclk(aclk), .rxd(rxd));

  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Watchdog, several times the expected run
  initial begin
    #500_000;
    err_count++;
    $display("unexpected at %0t: watchdog", $time);
    stop_test;
  end

  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, s, e);
    end
  endtask

  // Write: both channels at once, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 50);
    bready <= 1'b0;
    chk(32'({bvalid, bresp}), 32'({1'b1, er}), "write answer");
  endtask

  // Read: rready held until the answer is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 50);
    rready <= 1'b0;
    d = rdata;
    r = rvalid ? rresp : 2'h3;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(32'(r), 32'(RESP_OK), "rresp");
    chk(d, e, "rdata");
  endtask

  // Interrupt pin settles within a few cycles
  task automatic wirq(input logic e);
    int n;
    for (n = 0; n < 40 && irq !== e; n++) @(posedge aclk);
    chk(32'(irq), 32'(e), "irq");
  endtask

  task automatic pulse_tx;
    @(posedge aclk);
    tx_done <= 1'b1;
    @(posedge aclk);
    tx_done <= 1'b0;
  endtask

  // One frame, then status, receive flag and data judged and cleared
  task automatic frm(input logic [9:0] b, input int n, input logic ad, input logic nine,
                     input int per, input logic [3:0] st, input logic [8:0] dat);
    logic [31:0] d;
    logic [1:0]  r;
    u_line.send(b, n, ad, nine, per);
    wirq(1'b1);
    rchk(OFF_IRQ_STAT, 32'(st));
    rd(OFF_CTRL_A, d, r);
    chk(32'(d[B_RXC]), 32'(st[I_RXC]), "receive flag");
    chk(32'(d[B_FRMERR]), 32'h0, "frame error flag");
    if (st[I_RXC]) begin
      rd(OFF_DATA, d, r);
      chk(d, 32'(dat), "data");
    end
    wr(OFF_IRQ_STAT, 32'(st), RESP_OK);
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 6; i++) rchk(8'(4 * i), ZERO32);
    rd(8'h18, d, r);
    chk({d[29:0], r}, 32'(RESP_ERR), "unmapped read");
    wr(8'h18, 32'hffff_ffff, RESP_ERR);
    wr(OFF_BAUD, 32'h4, RESP_OK);
    rchk(OFF_BAUD, 32'h4);
    $display("done: registers");
  endtask

  // Transmit flag beside the filter bit, with and without its mask
  task automatic t_tx;
    wr(OFF_CTRL_A, 32'h1, RESP_OK);
    pulse_tx;
    rchk(OFF_CTRL_A, 32'h41);
    wirq(1'b0);
    wr(OFF_IRQ_MASK, 32'h8, RESP_OK);
    wirq(1'b1);
    wr(OFF_IRQ_STAT, 32'h8, RESP_OK);
    wirq(1'b0);
    pulse_tx;
    wirq(1'b1);
    wr(OFF_CTRL_A, 32'h41, RESP_OK);
    rchk(OFF_CTRL_A, 32'h1);
    wr(OFF_IRQ_STAT, 32'h8, RESP_OK);
    $display("done: transmit flag");
  endtask

  // Nine data bits: address kept, data dropped, then filter off
  task automatic t_mp9;
    wr(OFF_CTRL_B, 32'h9, RESP_OK);
    wr(OFF_IRQ_MASK, 32'hf, RESP_OK);
    frm(10'h0a3, 9, 1'b1, 1'b1, 80, 4'h3, 9'h1a3);
    frm(10'h055, 9, 1'b0, 1'b1, 80, 4'h4, 9'h0);
    rchk(OFF_DATA, 32'h1a3);
    wr(OFF_CTRL_A, ZERO32, RESP_OK);
    frm(10'h03c, 9, 1'b0, 1'b1, 80, 4'h1, 9'h03c);
    $display("done: nine-bit filtering");
  endtask

  // Type from the first stop bit; shortest and longest frames
  task automatic t_mp8;
    wr(OFF_CTRL_B, 32'h7, RESP_OK);
    wr(OFF_CTRL_A, 32'h1, RESP_OK);
    frm(10'h0c5, 8, 1'b0, 1'b0, 80, 4'h4, 9'h0);
    frm(10'h05a, 8, 1'b1, 1'b0, 80, 4'h3, 9'h05a);
    wr(OFF_CTRL_B, 32'h1, RESP_OK);
    frm(10'h015, 5, 1'b1, 1'b0, 80, 4'h3, 9'h015);
    wr(OFF_CTRL_B, 32'h19, RESP_OK);
    frm(10'h2a5, 10, 1'b1, 1'b1, 79, 4'h3, 9'h1a5);
    $display("done: stop-bit type and lengths");
  endtask

  // Double speed at eight samples per bit; a short glitch is no start
  task automatic t_speed;
    wr(OFF_CTRL_A, 32'h2, RESP_OK);
    wr(OFF_CTRL_B, 32'h9, RESP_OK);
    frm(10'h0e1, 9, 1'b0, 1'b1, 40, 4'h1, 9'h0e1);
    frm(10'h01e, 9, 1'b0, 1'b1, 40, 4'h1, 9'h01e);
    // Five-bit frame sent 2.5 percent fast still lands
    wr(OFF_CTRL_B, 32'h1, RESP_OK);
    frm(10'h016, 5, 1'b1, 1'b0, 39, 4'h3, 9'h016);
    u_line.drive(1'b0, 10);
    u_line.drive(1'b1, 600);
    chk(32'(irq), 32'h0, "glitch irq");
    rchk(OFF_IRQ_STAT, ZERO32);
    $display("done: double speed");
  endtask

  // Reset for 16 cycles, then the scenarios in turn
  initial begin
    err_count = 0;
    cmp_count = 0;
    aresetn   = 1'b0;
    awaddr    = '0;
    araddr    = '0;
    wdata     = '0;
    awvalid   = 1'b0;
    wvalid    = 1'b0;
    bready    = 1'b0;
    arvalid   = 1'b0;
    rready    = 1'b0;
    tx_done   = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_tx;
    t_mp9;
    t_mp8;
    t_speed;
    stop_test;
  end
endmodule

bind umpf_top umpf_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .tx_done(tx_done), .irq(irq),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
